// ### eli_defs.vh
`ifndef ELI_DEFS_VH
`define ELI_DEFS_VH
// ----------------------------------------------------------------
// code words on the mac and line sides
// ----------------------------------------------------------------
`define ELI_CW_IDLE      2'h0
`define ELI_CW_DATA      2'h1
`define ELI_CW_LPI       2'h2
// ----------------------------------------------------------------
// line symbols sent toward or taken from the partner
// ----------------------------------------------------------------
`define ELI_LN_NORMAL    3'h0
`define ELI_LN_SLEEP     3'h1
`define ELI_LN_QUIET     3'h2
`define ELI_LN_REFRESH   3'h3
`define ELI_LN_ALERT     3'h4
`define ELI_LN_WAKE      3'h5
// ----------------------------------------------------------------
// link speeds
// ----------------------------------------------------------------
`define ELI_SPD_100      3'h0
`define ELI_SPD_1G       3'h1
`define ELI_SPD_2G5      3'h2
`define ELI_SPD_5G       3'h3
`define ELI_SPD_10G      3'h4
// ----------------------------------------------------------------
// timing at 20 MHz (50 ns); times in ns
// ----------------------------------------------------------------
`define ELI_CLK_NS       50
`define ELI_TW_10G_NS    4480
`define ELI_TW_100_NS    20500
`define ELI_TW_1G_NS     16500
`define ELI_TW_10G_CYC   (`ELI_TW_10G_NS / `ELI_CLK_NS)
`define ELI_TW_100_CYC   (`ELI_TW_100_NS / `ELI_CLK_NS)
`define ELI_TW_1G_CYC    (`ELI_TW_1G_NS / `ELI_CLK_NS)
`define ELI_ALERT_CYC    16'h0010
`define ELI_SLEEP_CYC    16'h0008
`define ELI_QUIET_CYC    16'h0100
`define ELI_REFRESH_CYC  16'h0010
`define ELI_FIFO_DEPTH   8
`endif

// ### eli_fifo.v
module eli_fifo #(
  parameter WIDTH = 10,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clk_in,
  input  wire             rstn_in,
  input  wire [WIDTH-1:0] wr_data_in,
  input  wire             wr_valid_in,
  output wire             wr_ready_out,
  output wire [WIDTH-1:0] rd_data_out,
  output wire             rd_valid_out,
  input  wire             rd_ready_in
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wptr_ff;
  reg [AW:0]      rptr_ff;
  wire            full;
  wire            empty;
  wire            do_wr;
  wire            do_rd;

  assign full         = (wptr_ff[AW-1:0] == rptr_ff[AW-1:0]) &&
                        (wptr_ff[AW] != rptr_ff[AW]);
  assign empty        = (wptr_ff == rptr_ff);
  assign wr_ready_out = ~full;
  assign rd_valid_out = ~empty;
  assign rd_data_out  = mem[rptr_ff[AW-1:0]];
  assign do_wr        = wr_valid_in & ~full;
  assign do_rd        = rd_ready_in & ~empty;

  always @(posedge clk_in) begin
    if (do_wr)
      mem[wptr_ff[AW-1:0]] <= wr_data_in;
  end

  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wptr_ff <= {(AW+1){1'b0}};
      rptr_ff <= {(AW+1){1'b0}};
    end else begin
      if (do_wr)
        wptr_ff <= wptr_ff + 1'b1;
      if (do_rd)
        rptr_ff <= rptr_ff + 1'b1;
    end
  end
endmodule // eli_fifo

// ### eli_rx_seq.v
`include "eli_defs.vh"
module eli_rx_seq (
  input  wire       clk_in,
  input  wire       rstn_in,
  input  wire       link_up_in,
  input  wire       eee_active_in,
  input  wire [2:0] speed_in,
  input  wire [2:0] line_rx_sym_in,
  input  wire [1:0] line_rx_cw_in,
  input  wire [15:0] tw_cyc_in,
  output reg        rx_lpi_out,
  output reg        rx_low_power_out,
  output reg        rx_adapt_out,
  output reg        rx_ready_out
);
  localparam S_NORM  = 2'h0;
  localparam S_QUIET = 2'h1;
  localparam S_WAKE  = 2'h2;

  reg [1:0]  st_ff;
  reg [15:0] cnt_ff;

  // ----------------------------------------------------------------
  // receive sequencer
  // ----------------------------------------------------------------
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_ff            <= S_NORM;
      cnt_ff           <= 16'h0000;
      rx_lpi_out       <= 1'b0;
      rx_low_power_out <= 1'b0;
      rx_adapt_out     <= 1'b0;
      rx_ready_out     <= 1'b0;
    end else if (!link_up_in) begin
      st_ff            <= S_NORM;
      cnt_ff           <= 16'h0000;
      rx_lpi_out       <= 1'b0;
      rx_low_power_out <= 1'b0;
      rx_adapt_out     <= 1'b0;
      rx_ready_out     <= 1'b0;
    end else begin
      rx_adapt_out <= 1'b0;
      case (st_ff)
        S_NORM: begin
          rx_ready_out <= 1'b1;
          // partner lpi is relayed even when the line cannot go quiet
          rx_lpi_out   <= (line_rx_cw_in == `ELI_CW_LPI);
          if (eee_active_in && line_rx_cw_in == `ELI_CW_LPI) begin
            st_ff        <= S_QUIET;
            rx_ready_out <= 1'b0;
          end
        end
        S_QUIET: begin
          rx_low_power_out <= (line_rx_sym_in == `ELI_LN_QUIET);
          rx_adapt_out <= (line_rx_sym_in == `ELI_LN_REFRESH);
          if (line_rx_sym_in == `ELI_LN_WAKE ||
              (speed_in == `ELI_SPD_10G &&
               line_rx_sym_in == `ELI_LN_ALERT)) begin
            st_ff            <= S_WAKE;
            cnt_ff           <= tw_cyc_in;
            rx_low_power_out <= 1'b0;
          end
        end
        S_WAKE: begin
          rx_lpi_out <= 1'b0;
          if (cnt_ff == 16'h0000) begin
            st_ff        <= S_NORM;
            rx_ready_out <= 1'b1;
          end else begin
            cnt_ff <= cnt_ff - 16'h0001;
          end
        end
        default: st_ff <= S_NORM;
      endcase
    end
  end
endmodule // eli_rx_seq

// ### eli_lpi_ctrl.v
`include "eli_defs.vh"
module eli_lpi_ctrl (
  input  wire        core_clk_in,
  input  wire        resetn_in,
  input  wire        link_up_in,
  input  wire [2:0]  speed_in,
  input  wire        an_enable_in,
  input  wire        eee_adv_in,
  input  wire        lp_eee_in,
  input  wire        auto_mode_in,
  input  wire [15:0] idle_thresh_in,
  input  wire        tw_override_in,
  input  wire [15:0] tw_cyc_in,
  input  wire [1:0]  mac_cw_in,
  input  wire [7:0]  mac_data_in,
  input  wire        mac_valid_in,
  output wire        mac_ready_out,
  input  wire [2:0]  line_rx_sym_in,
  input  wire [1:0]  line_rx_cw_in,
  output reg  [2:0]  line_tx_sym_out,
  output reg  [1:0]  line_tx_cw_out,
  output reg  [7:0]  line_tx_data_out,
  output reg         tx_lpi_state_out,
  output reg         tx_wake_done_out,
  output reg         link_refresh_out,
  output wire        rx_lpi_out,
  output wire        rx_low_power_out,
  output wire        rx_adapt_out,
  output wire        rx_ready_out
);
  localparam S_NORM    = 3'h0;
  localparam S_SLEEP   = 3'h1;
  localparam S_WAITLP  = 3'h2;
  localparam S_QUIET   = 3'h3;
  localparam S_REFRESH = 3'h4;
  localparam S_ALERT   = 3'h5;
  localparam S_WAKE    = 3'h6;

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  reg rst_s1_ff;
  reg rst_s2_ff;
  always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end
  wire rstn = rst_s2_ff;

  // ----------------------------------------------------------------
  // wake time selection
  // ----------------------------------------------------------------
  function [15:0] tw_default;
    input [2:0]  spd;
    reg   [31:0] full_cyc;
    begin
      case (spd)
        `ELI_SPD_100: full_cyc = `ELI_TW_100_CYC;
        `ELI_SPD_1G:  full_cyc = `ELI_TW_1G_CYC;
        default:      full_cyc = `ELI_TW_10G_CYC;
      endcase
      tw_default = full_cyc[15:0];
    end
  endfunction

  wire [15:0] tw_cyc = tw_override_in ? tw_cyc_in
                                      : tw_default(speed_in);
  wire        is_10g = (speed_in == `ELI_SPD_10G);
  // alert and both state hand-overs come out of the 10g wake budget,
  // so alert plus wake never exceed the maximum recovery time while tw_cyc is at least 18
  wire [15:0] tw_body = is_10g ? tw_cyc - `ELI_ALERT_CYC - 16'h0002
                               : tw_cyc;

  // eee capability gate
  wire eee_active = link_up_in & an_enable_in & eee_adv_in &
                    lp_eee_in;

  // ----------------------------------------------------------------
  // data path fifo: words are held, never dropped, while waking
  // ----------------------------------------------------------------
  wire [9:0] f_rd_data;
  wire       f_rd_valid;
  reg        f_rd_ready;

  eli_fifo #(
    .WIDTH (10),
    .DEPTH (`ELI_FIFO_DEPTH),
    .AW    (3)
  ) u_fifo (
    .clk_in       (core_clk_in),
    .rstn_in      (rstn),
    .wr_data_in   ({mac_cw_in, mac_data_in}),
    .wr_valid_in  (mac_valid_in),
    .wr_ready_out (mac_ready_out),
    .rd_data_out  (f_rd_data),
    .rd_valid_out (f_rd_valid),
    .rd_ready_in  (f_rd_ready)
  );

  wire [1:0] head_cw = f_rd_data[9:8];

  // ----------------------------------------------------------------
  // lpi request: native code words or autonomous idle count
  // ----------------------------------------------------------------
  reg [15:0] idle_cnt_ff;
  wire       head_idle = f_rd_valid & (head_cw == `ELI_CW_IDLE);
  wire       head_busy = f_rd_valid & (head_cw == `ELI_CW_DATA);
  always @(posedge core_clk_in or negedge rstn) begin
    if (!rstn)
      idle_cnt_ff <= 16'h0000;
    else if (!auto_mode_in || head_busy || !link_up_in)
      idle_cnt_ff <= 16'h0000;
    else if (head_idle && idle_cnt_ff != 16'hffff)
      idle_cnt_ff <= idle_cnt_ff + 16'h0001;
  end

  // in native mode only mac code words steer entry and exit
  wire lpi_req = auto_mode_in
               ? (idle_cnt_ff >= idle_thresh_in) & ~head_busy
               : f_rd_valid & (head_cw == `ELI_CW_LPI);
  wire exit_req = auto_mode_in ? head_busy
                : f_rd_valid & (head_cw != `ELI_CW_LPI);

  // ----------------------------------------------------------------
  // transmit sequencer
  // ----------------------------------------------------------------
  reg [2:0]  st_ff;
  reg [15:0] cnt_ff;
  reg        rem_sleep_ff;

  always @* begin
    // words are consumed except in alert and wake and, outside normal, on an exit request; wake holds data back
    case (st_ff)
      S_ALERT, S_WAKE: f_rd_ready = 1'b0;
      S_NORM:          f_rd_ready = 1'b1;
      default:         f_rd_ready = ~exit_req;
    endcase
  end

  always @(posedge core_clk_in or negedge rstn) begin
    if (!rstn) begin
      st_ff            <= S_NORM;
      cnt_ff           <= 16'h0000;
      rem_sleep_ff     <= 1'b0;
      line_tx_sym_out  <= `ELI_LN_NORMAL;
      line_tx_cw_out   <= `ELI_CW_IDLE;
      line_tx_data_out <= 8'h00;
      tx_lpi_state_out <= 1'b0;
      tx_wake_done_out <= 1'b0;
      link_refresh_out <= 1'b0;
    end else if (!link_up_in) begin
      st_ff            <= S_NORM;
      cnt_ff           <= 16'h0000;
      rem_sleep_ff     <= 1'b0;
      line_tx_sym_out  <= `ELI_LN_NORMAL;
      line_tx_cw_out   <= `ELI_CW_IDLE;
      tx_lpi_state_out <= 1'b0;
      tx_wake_done_out <= 1'b0;
      link_refresh_out <= 1'b0;
    end else begin
      tx_wake_done_out <= 1'b0;
      link_refresh_out <= 1'b0;
      if (line_rx_sym_in == `ELI_LN_SLEEP)
        rem_sleep_ff <= 1'b1;
      case (st_ff)
        S_NORM: begin
          line_tx_sym_out <= `ELI_LN_NORMAL;
          tx_lpi_state_out <= 1'b0;
          if (f_rd_valid) begin
            line_tx_cw_out   <= head_cw;
            line_tx_data_out <= f_rd_data[7:0];
          end else begin
            line_tx_cw_out <= `ELI_CW_IDLE;
          end
          if (lpi_req) begin
            // lpi is relayed to the far end whether or not we go quiet
            line_tx_cw_out <= `ELI_CW_LPI;
            if (eee_active) begin
              st_ff            <= S_SLEEP;
              cnt_ff           <= `ELI_SLEEP_CYC;
              // a partner sleep seen on the entry edge still counts
              rem_sleep_ff     <= (line_rx_sym_in == `ELI_LN_SLEEP);
              tx_lpi_state_out <= 1'b1;
            end
          end
        end
        S_SLEEP: begin
          line_tx_sym_out <= `ELI_LN_SLEEP;
          line_tx_cw_out  <= `ELI_CW_LPI;
          if (exit_req) begin
            st_ff  <= is_10g ? S_ALERT : S_WAKE;
            cnt_ff <= is_10g ? `ELI_ALERT_CYC : tw_cyc;
          end else if (cnt_ff != 16'h0000) begin
            cnt_ff <= cnt_ff - 16'h0001;
          end else if (speed_in == `ELI_SPD_1G) begin
            st_ff <= S_WAITLP;
          end else begin
            st_ff  <= S_QUIET;
            cnt_ff <= `ELI_QUIET_CYC;
          end
        end
        S_WAITLP: begin
          // no quiet until the partner also slept; lpi keeps flowing
          line_tx_sym_out <= `ELI_LN_SLEEP;
          if (exit_req) begin
            st_ff  <= S_WAKE;
            cnt_ff <= tw_cyc;
          end else if (rem_sleep_ff) begin
            st_ff  <= S_QUIET;
            cnt_ff <= `ELI_QUIET_CYC;
          end
        end
        S_QUIET: begin
          line_tx_sym_out <= `ELI_LN_QUIET;
          if (exit_req) begin
            st_ff  <= is_10g ? S_ALERT : S_WAKE;
            cnt_ff <= is_10g ? `ELI_ALERT_CYC : tw_cyc;
          end else if (cnt_ff == 16'h0000) begin
            st_ff  <= S_REFRESH;
            cnt_ff <= `ELI_REFRESH_CYC;
          end else begin
            cnt_ff <= cnt_ff - 16'h0001;
          end
        end
        S_REFRESH: begin
          line_tx_sym_out  <= `ELI_LN_REFRESH;
          link_refresh_out <= 1'b1;
          if (exit_req) begin
            st_ff  <= is_10g ? S_ALERT : S_WAKE;
            cnt_ff <= is_10g ? `ELI_ALERT_CYC : tw_cyc;
          end else if (cnt_ff == 16'h0000) begin
            st_ff  <= S_QUIET;
            cnt_ff <= `ELI_QUIET_CYC;
          end else begin
            cnt_ff <= cnt_ff - 16'h0001;
          end
        end
        S_ALERT: begin
          line_tx_sym_out <= `ELI_LN_ALERT;
          if (cnt_ff == 16'h0000) begin
            st_ff  <= S_WAKE;
            cnt_ff <= tw_body;
          end else begin
            cnt_ff <= cnt_ff - 16'h0001;
          end
        end
        S_WAKE: begin
          line_tx_sym_out <= `ELI_LN_WAKE;
          line_tx_cw_out  <= `ELI_CW_IDLE;
          if (cnt_ff == 16'h0000) begin
            st_ff            <= S_NORM;
            tx_lpi_state_out <= 1'b0;
            tx_wake_done_out <= 1'b1;
          end else begin
            cnt_ff <= cnt_ff - 16'h0001;
          end
        end
        default: st_ff <= S_NORM;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // receive direction
  // ----------------------------------------------------------------
  eli_rx_seq u_rx (
    .clk_in           (core_clk_in),
    .rstn_in          (rstn),
    .link_up_in       (link_up_in),
    .eee_active_in    (eee_active),
    .speed_in         (speed_in),
    .line_rx_sym_in   (line_rx_sym_in),
    .line_rx_cw_in    (line_rx_cw_in),
    .tw_cyc_in        (tw_cyc),
    .rx_lpi_out       (rx_lpi_out),
    .rx_low_power_out (rx_low_power_out),
    .rx_adapt_out     (rx_adapt_out),
    .rx_ready_out     (rx_ready_out)
  );
endmodule // eli_lpi_ctrl

// ### eli_lpi_chk.sv
`include "eli_defs.vh"
module eli_lpi_chk (
  input wire       core_clk_in,
  input wire       resetn_in,
  input wire       link_up_in,
  input wire [2:0] speed_in,
  input wire       an_enable_in,
  input wire       eee_adv_in,
  input wire       lp_eee_in,
  input wire [2:0] line_rx_sym_in,
  input wire [2:0] line_tx_sym_out,
  input wire       tx_lpi_state_out,
  input wire       tx_wake_done_out,
  input wire       link_refresh_out,
  input wire       rx_lpi_out,
  input wire       rx_low_power_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // helpers
  // ----
  wire      tx_quiet = (line_tx_sym_out == `ELI_LN_QUIET);
  reg [9:0] qrun_ff;
  reg       psleep_ff;
  // partner sleep only counts inside our own lpi sequence
  always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      qrun_ff   <= 10'h000;
      psleep_ff <= 1'b0;
    end else begin
      qrun_ff   <= tx_quiet ? qrun_ff + 10'h001 : 10'h000;
      psleep_ff <= tx_lpi_state_out &
                   (psleep_ff | (line_rx_sym_in == `ELI_LN_SLEEP));
    end
  end
  // ----
  // properties
  // ----
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);
  link_drop_a: assert property (
    !link_up_in |=> !tx_lpi_state_out) else $error("lpi kept on link loss");
  gate_hold_a: assert property (
    !(an_enable_in & eee_adv_in & lp_eee_in) & !tx_lpi_state_out
    |=> !tx_lpi_state_out) else $error("lpi entered while gated");
  sleep_first_a: assert property (
    $rose(tx_lpi_state_out) |=> line_tx_sym_out == `ELI_LN_SLEEP)
    else $error("lpi entry without sleep");
  quiet_bound_a: assert property (qrun_ff <= 10'h12C)
    else $error("quiet without refresh");
  gig_shake_a: assert property (
    $rose(tx_quiet) && speed_in == `ELI_SPD_1G |-> psleep_ff)
    else $error("1g quiet before partner sleep");
  refresh_flag_a: assert property (
    link_refresh_out |-> line_tx_sym_out == `ELI_LN_REFRESH)
    else $error("refresh flag outside refresh");
  alert_wake_a: assert property (
    $rose(line_tx_sym_out == `ELI_LN_WAKE) && speed_in == `ELI_SPD_10G
    |-> $past(line_tx_sym_out) == `ELI_LN_ALERT) else $error("no alert");
  wake_pulse_a: assert property (
    tx_wake_done_out |=> !tx_wake_done_out) else $error("wake done held");
  wake_end_a: assert property (
    $rose(tx_wake_done_out) |-> $past(line_tx_sym_out) == `ELI_LN_WAKE)
    else $error("wake done without wake");
  rx_power_a: assert property (
    rx_low_power_out |-> rx_lpi_out) else $error("rx power down no lpi");
  cover property (tx_wake_done_out);
  cover property (link_refresh_out);
  cover property ($rose(rx_low_power_out));
endmodule // eli_lpi_chk
bind eli_lpi_ctrl eli_lpi_chk u_chk (
  .core_clk_in      (core_clk_in),
  .resetn_in        (resetn_in),
  .link_up_in       (link_up_in),
  .speed_in         (speed_in),
  .an_enable_in     (an_enable_in),
  .eee_adv_in       (eee_adv_in),
  .lp_eee_in        (lp_eee_in),
  .line_rx_sym_in   (line_rx_sym_in),
  .line_tx_sym_out  (line_tx_sym_out),
  .tx_lpi_state_out (tx_lpi_state_out),
  .tx_wake_done_out (tx_wake_done_out),
  .link_refresh_out (link_refresh_out),
  .rx_lpi_out       (rx_lpi_out),
  .rx_low_power_out (rx_low_power_out)
);

// ### eli_rphy.sv
`include "eli_defs.vh"
module eli_rphy (
  input  wire       clk_in,
  input  wire       lpi_req_in,
  input  wire       alert_en_in,
  output reg  [2:0] sym_out,
  output reg  [1:0] cw_out
);
  timeunit 1ns;
  timeprecision 1ns;
  reg [4:0] cnt_ff;
  task step(input [2:0] s);
    sym_out <= s;
    cnt_ff  <= 5'h00;
  endtask
  initial begin
    sym_out = `ELI_LN_NORMAL;
    cw_out  = `ELI_CW_IDLE;
    cnt_ff  = 5'h00;
  end
  // short quiet keeps partner refresh visible within a few dozen cycles
  always @(posedge clk_in) begin
    cnt_ff <= cnt_ff + 5'h01;
    cw_out <= lpi_req_in ? `ELI_CW_LPI : `ELI_CW_IDLE;
    if (lpi_req_in) begin
      case (sym_out)
        `ELI_LN_NORMAL:  step(`ELI_LN_SLEEP);
        `ELI_LN_SLEEP:   if (cnt_ff == 5'h07) step(`ELI_LN_QUIET);
        `ELI_LN_QUIET:   if (cnt_ff == 5'h1F) step(`ELI_LN_REFRESH);
        `ELI_LN_REFRESH: if (cnt_ff == 5'h07) step(`ELI_LN_QUIET);
        default: ;
      endcase
    end else begin
      case (sym_out)
        `ELI_LN_NORMAL: ;
        `ELI_LN_ALERT: if (cnt_ff == 5'h07) step(`ELI_LN_WAKE);
        `ELI_LN_WAKE:  if (cnt_ff == 5'h0F) step(`ELI_LN_NORMAL);
        default: step(alert_en_in ? `ELI_LN_ALERT : `ELI_LN_WAKE);
      endcase
    end
  end
endmodule // eli_rphy

// ### eli_tb.sv
`include "eli_defs.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("FAIL %0t got %0h exp %0h", $time, a, b); end end
  logic        clk, rstn, link_up, an_en, adv, lp_eee, auto, tw_ov;
  logic        m_valid, p_req, m_ready, lpi_st, wk_done, refr;
  logic        rx_lpi, rx_lp, rx_adapt, rx_rdy;
  logic [2:0]  speed, rx_sym, tx_sym;
  logic [1:0]  m_cw, rx_cw, tx_cw;
  logic [7:0]  m_data, tx_data, last;
  logic [15:0] thresh, tw_cyc;
  logic [7:0]  got[$];
  int          error_cnt, n_checks, cyc;
  eli_lpi_ctrl u_dut (.core_clk_in(clk), .resetn_in(rstn),
    .link_up_in(link_up), .speed_in(speed), .an_enable_in(an_en),
    .eee_adv_in(adv), .lp_eee_in(lp_eee), .auto_mode_in(auto),
    .idle_thresh_in(thresh), .tw_override_in(tw_ov), .tw_cyc_in(tw_cyc),
    .mac_cw_in(m_cw), .mac_data_in(m_data), .mac_valid_in(m_valid),
    .mac_ready_out(m_ready), .line_rx_sym_in(rx_sym),
    .line_rx_cw_in(rx_cw), .line_tx_sym_out(tx_sym), .line_tx_cw_out(tx_cw),
    .line_tx_data_out(tx_data), .tx_lpi_state_out(lpi_st),
    .tx_wake_done_out(wk_done), .link_refresh_out(refr),
    .rx_lpi_out(rx_lpi), .rx_low_power_out(rx_lp),
    .rx_adapt_out(rx_adapt), .rx_ready_out(rx_rdy));
  eli_rphy u_rp (.clk_in(clk), .lpi_req_in(p_req),
    .alert_en_in(speed == `ELI_SPD_10G), .sym_out(rx_sym), .cw_out(rx_cw));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  always @(negedge clk) begin
    if (tx_cw === `ELI_CW_DATA && tx_data !== last) begin
      got.push_back(tx_data);
      last = tx_data;
    end
  end
  task report_and_stop;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ----
  // scenarios
  // ----
  // called at a rising edge; returns at the edge that takes the word
  task send(input [1:0] c, input [7:0] d);
    m_cw <= c;
    m_data <= d;
    m_valid <= 1'b1;
    @(negedge clk);
    while (m_ready !== 1'b1) @(negedge clk);
    @(posedge clk);
  endtask
  task wait_sym(input [2:0] s, input int lim);
    int n;
    n = 0;
    do begin @(negedge clk); n++; end while (tx_sym !== s && n < lim);
    `CHK(tx_sym, s)
  endtask
  task lpi_cycle(input [2:0] spd, input ov, input int tw);
    int n, k;
    @(posedge clk);
    speed <= spd;
    tw_ov <= ov;
    tw_cyc <= tw[15:0];
    send(`ELI_CW_LPI, 8'h00);
    m_valid <= 1'b0;
    wait_sym(`ELI_LN_SLEEP, 8);
    `CHK(lpi_st, 1'b1)
    repeat (40) @(negedge clk);
    if (spd == `ELI_SPD_100) `CHK(tx_sym, `ELI_LN_QUIET)
    if (spd == `ELI_SPD_1G) begin
      `CHK(tx_sym === `ELI_LN_QUIET, 1'b0)
      `CHK(tx_cw, `ELI_CW_LPI)
    end
    p_req <= (spd != `ELI_SPD_100);
    wait_sym(`ELI_LN_QUIET, 300);
    wait_sym(`ELI_LN_REFRESH, 300);
    `CHK(refr, 1'b1)
    wait_sym(`ELI_LN_QUIET, 40);
    if (spd != `ELI_SPD_100) begin
      `CHK(rx_lpi, 1'b1)
      n = 0;
      while (rx_sym !== `ELI_LN_REFRESH && n < 60) begin
        @(negedge clk);
        n++;
      end
      repeat (3) @(negedge clk);
      `CHK(rx_adapt, 1'b1)
      n = 0;
      while (rx_sym !== `ELI_LN_QUIET && n < 60) begin
        @(negedge clk);
        n++;
      end
      repeat (2) @(negedge clk);
      `CHK(rx_lp, 1'b1)
    end
    @(posedge clk);
    send(`ELI_CW_IDLE, 8'h00);
    m_valid <= 1'b0;
    p_req <= 1'b0;
    do @(negedge clk); while (tx_sym === `ELI_LN_QUIET ||
      tx_sym === `ELI_LN_REFRESH);
    `CHK(tx_sym, spd == `ELI_SPD_10G ? `ELI_LN_ALERT : `ELI_LN_WAKE)
    n = 0;
    k = 0;
    if (spd == `ELI_SPD_10G) begin
      got.delete();
      last = 8'hFF;
      @(posedge clk);
      m_cw <= `ELI_CW_DATA;
      m_valid <= 1'b1;
      repeat (12) begin
        m_data <= 8'h40 + k[7:0];
        @(negedge clk);
        n++;
        if (m_ready === 1'b1) k++;
        @(posedge clk);
      end
      m_valid <= 1'b0;
      `CHK(k >= 7 && k <= 8, 1'b1)
    end
    while (wk_done !== 1'b1 && n < 1000) begin
      @(negedge clk);
      n++;
    end
    `CHK(n <= tw && n + 2 >= tw, 1'b1)
    if (spd == `ELI_SPD_10G) begin
      repeat (20) @(negedge clk);
      `CHK(got.size(), k)
      foreach (got[i]) `CHK(got[i], 8'h40 + i[7:0])
    end
    n = 0;
    while (rx_rdy !== 1'b1 && n < 1000) begin
      @(negedge clk);
      n++;
    end
    if (spd != `ELI_SPD_100) `CHK(rx_rdy, 1'b1)
  endtask
  task s_gate;
    int i;
    for (i = 0; i < 3; i++) begin
      @(posedge clk);
      an_en <= (i != 0);
      adv <= (i != 1);
      lp_eee <= (i != 2);
      send(`ELI_CW_LPI, 8'h00);
      m_valid <= 1'b0;
      repeat (20) @(negedge clk);
      `CHK(lpi_st, 1'b0)
      @(posedge clk);
      send(`ELI_CW_IDLE, 8'h00);
      m_valid <= 1'b0;
    end
    an_en <= 1'b1;
    adv <= 1'b1;
    lp_eee <= 1'b1;
  endtask
  task s_auto;
    int i;
    @(posedge clk);
    auto <= 1'b1;
    speed <= `ELI_SPD_100;
    for (i = 0; i < 8; i++)
      send(i == 3 ? `ELI_CW_DATA : `ELI_CW_IDLE, 8'h00);
    m_valid <= 1'b0;
    repeat (10) @(negedge clk);
    `CHK(lpi_st, 1'b0)
    @(posedge clk);
    send(`ELI_CW_IDLE, 8'h00);
    send(`ELI_CW_IDLE, 8'h00);
    m_valid <= 1'b0;
    repeat (10) @(negedge clk);
    `CHK(lpi_st, 1'b1)
    @(posedge clk);
    send(`ELI_CW_DATA, 8'h5A);
    m_valid <= 1'b0;
    i = 0;
    while (wk_done !== 1'b1 && i < 800) begin
      @(negedge clk);
      i++;
    end
    `CHK(wk_done, 1'b1)
    @(posedge clk);
    auto <= 1'b0;
  endtask
  task s_link;
    @(posedge clk);
    speed <= `ELI_SPD_100;
    send(`ELI_CW_LPI, 8'h00);
    m_valid <= 1'b0;
    wait_sym(`ELI_LN_QUIET, 60);
    @(posedge clk);
    link_up <= 1'b0;
    send(`ELI_CW_IDLE, 8'h00);
    m_valid <= 1'b0;
    repeat (3) @(negedge clk);
    `CHK(lpi_st, 1'b0)
    `CHK(tx_sym, `ELI_LN_NORMAL)
    @(posedge clk);
    link_up <= 1'b1;
    repeat (30) @(negedge clk);
    `CHK(lpi_st, 1'b0)
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    {rstn, tw_ov, auto, m_valid, p_req} = 5'h00;
    {link_up, an_en, adv, lp_eee} = 4'hF;
    speed = `ELI_SPD_100;
    thresh = 16'h0005;
    tw_cyc = 16'h0028;
    m_cw = `ELI_CW_IDLE;
    m_data = 8'h00;
    last = 8'hFF;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    s_gate;
    lpi_cycle(`ELI_SPD_100, 1'b0, `ELI_TW_100_CYC);
    lpi_cycle(`ELI_SPD_100, 1'b1, 40);
    lpi_cycle(`ELI_SPD_1G, 1'b0, `ELI_TW_1G_CYC);
    lpi_cycle(`ELI_SPD_10G, 1'b0, `ELI_TW_10G_CYC);
    s_auto;
    s_link;
    report_and_stop();
  end
endmodule // tb
